/* include/tfe_pkg.sv */
// Shared constants and types for the timer-0 flag and ext-irq-1 block.
// Assumes a 32-bit Avalon-MM slave port with byte addresses.
package tfe_pkg;

	// Bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam int BE_W = 4;

	// Register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_IRQ_STS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MSK = 4'h8;
	localparam logic [3:0] OFS_PIN = 4'hC;

	// Control register field positions
	localparam int BIT_OVF_FLAG = 5;
	localparam int BIT_RUN = 4;
	localparam int BIT_DET_FLAG = 3;
	localparam int BIT_TRIG_TYPE = 2;

	// Interrupt status and mask field positions
	localparam int IRQ_W = 2;
	localparam int IRQ_OVF = 0;
	localparam int IRQ_DET = 1;

	// Pin register field position
	localparam int BIT_PIN = 0;

	// Reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [1:0] IRQ_STS_RST = 2'h0;
	localparam logic [1:0] IRQ_MSK_RST = 2'h0;
	localparam logic PIN_IDLE = 1'b1;

	// Trigger type encoding held in the type bit
	localparam logic TRIG_LEVEL = 1'b0;
	localparam logic TRIG_EDGE = 1'b1;

	// Control byte layout
	typedef struct packed {
		logic [1:0] spare_hi;
		logic timer_zero_overflow_flag;
		logic timer_zero_run;
		logic ext_irq_one_detect_flag;
		logic ext_irq_one_trigger_type;
		logic [1:0] spare_lo;
	} tfe_ctrl_t;

	// One bus request as seen by the slave
	typedef struct packed {
		logic [ADDR_W-1:0] address;
		logic read;
		logic write;
		logic [DATA_W-1:0] writedata;
		logic [BE_W-1:0] byteenable;
	} tfe_req_t;

endpackage

/* src/tfe_sync.sv */
// Two-stage level synchroniser with a constant reset level.
// Assumes a single clock domain on the output side.
`timescale 1ns/1ps
module tfe_sync #(
	parameter logic RESET_VAL = 1'b1
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Data
	input wire logic d_i,
	output logic q_o
);

	logic meta_q;
	logic sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end
		else
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule

/* src/tfe_sticky.sv */
// Sticky event bits cleared by writing one; a set beats a clear.
// Assumes set and clear strobes are synchronous to clk_i.
`timescale 1ns/1ps
module tfe_sticky #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Events and clears
	input wire logic [WIDTH-1:0] set_i,
	input wire logic [WIDTH-1:0] clr_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] bits_q;

	// Events landing on a clear cycle survive
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			bits_q <= '0;
		else
			bits_q <= set_i | (bits_q & ~clr_i);
	end

	assign q_o = bits_q;

endmodule

/* src/tfe_irq_ctrl.sv */
// Timer-0 overflow flag and run bit, ext-irq-1 detect flag and type.
// Assumes overflow and service-entry strobes are one-cycle pulses from
// the timer and interrupt core on sys_clk_i; pin is active low.
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps

module tfe_irq_ctrl (
	// Clock and reset
	input wire logic sys_clk_i,
	input wire logic reset_i,
	// Avalon-MM slave
	input wire logic [tfe_pkg::ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [tfe_pkg::DATA_W-1:0] avs_writedata_i,
	input wire logic [tfe_pkg::BE_W-1:0] avs_byteenable_i,
	output logic [tfe_pkg::DATA_W-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Timer and interrupt core
	input wire logic timer_overflow_i,
	input wire logic t0_isr_enter_i,
	input wire logic ext1_isr_enter_i,
	output logic timer_zero_run_o,
	output logic timer_zero_overflow_flag_o,
	output logic ext_irq_one_detect_flag_o,
	output logic ext_irq_one_trigger_type_o,
	// External pin
	input wire logic ext_irq_one_pin_n_i,
	// Interrupt
	output logic irq_o
);

	tfe_pkg::tfe_req_t req;
	tfe_pkg::tfe_ctrl_t wr_ctrl;
	logic wait_q;
	logic [tfe_pkg::DATA_W-1:0] rdata_q;
	logic [tfe_pkg::DATA_W-1:0] rdata_d;
	logic acc;
	logic wr_ok;
	logic ctrl_wr;
	logic sts_wr;
	logic msk_wr;
	logic ovf_flag_q;
	logic ovf_flag_d;
	logic run_q;
	logic det_q;
	logic det_d;
	logic trig_type_q;
	logic pin_s;
	logic pin_prev_q;
	logic fall;
	logic [tfe_pkg::IRQ_W-1:0] sts;
	logic [tfe_pkg::IRQ_W-1:0] sts_set;
	logic [tfe_pkg::IRQ_W-1:0] sts_clr;
	logic [tfe_pkg::IRQ_W-1:0] msk_q;
	logic irq_q;

	assign req.address = avs_address_i;
	assign req.read = avs_read_i;
	assign req.write = avs_write_i;
	assign req.writedata = avs_writedata_i;
	assign req.byteenable = avs_byteenable_i;
	assign wr_ctrl = req.writedata[7:0];

	// Bus handshake: one wait cycle, then the transfer completes
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			wait_q <= 1'b1;
		else if ((req.read || req.write) && wait_q)
			wait_q <= 1'b0;
		else
			wait_q <= 1'b1;
	end

	assign acc = (req.read || req.write) && !wait_q;
	assign wr_ok = acc && req.write && req.byteenable[0];
	assign ctrl_wr = wr_ok && (req.address == tfe_pkg::OFS_CTRL);
	assign sts_wr = wr_ok && (req.address == tfe_pkg::OFS_IRQ_STS);
	assign msk_wr = wr_ok && (req.address == tfe_pkg::OFS_IRQ_MSK);

	// Read mux; unmapped offsets read as zero
	always_comb
	begin
		rdata_d = '0;
		if (req.address == tfe_pkg::OFS_CTRL)
		begin
			rdata_d[tfe_pkg::BIT_OVF_FLAG] = ovf_flag_q;
			rdata_d[tfe_pkg::BIT_RUN] = run_q;
			rdata_d[tfe_pkg::BIT_DET_FLAG] = det_q;
			rdata_d[tfe_pkg::BIT_TRIG_TYPE] = trig_type_q;
		end
		else if (req.address == tfe_pkg::OFS_IRQ_STS)
			rdata_d[tfe_pkg::IRQ_W-1:0] = sts;
		else if (req.address == tfe_pkg::OFS_IRQ_MSK)
			rdata_d[tfe_pkg::IRQ_W-1:0] = msk_q;
		else if (req.address == tfe_pkg::OFS_PIN)
			rdata_d[tfe_pkg::BIT_PIN] = pin_s;
	end

	// Data captured in the wait cycle stand at the completing edge
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			rdata_q <= '0;
		else if (req.read && wait_q)
			rdata_q <= rdata_d;
	end

	// Overflow flag: hardware set beats service clear and software write
	always_comb
	begin
		ovf_flag_d = ovf_flag_q;
		if (ctrl_wr)
			ovf_flag_d = wr_ctrl.timer_zero_overflow_flag;
		else if (t0_isr_enter_i)
			ovf_flag_d = 1'b0;
		if (timer_overflow_i)
			ovf_flag_d = 1'b1;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			ovf_flag_q <= tfe_pkg::CTRL_RST[tfe_pkg::BIT_OVF_FLAG];
		else
			ovf_flag_q <= ovf_flag_d;
	end

	// Run bit only changes by software
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			run_q <= tfe_pkg::CTRL_RST[tfe_pkg::BIT_RUN];
		else if (ctrl_wr)
			run_q <= wr_ctrl.timer_zero_run;
	end

	// Trigger type select
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			trig_type_q <= tfe_pkg::CTRL_RST[tfe_pkg::BIT_TRIG_TYPE];
		else if (ctrl_wr)
			trig_type_q <= wr_ctrl.ext_irq_one_trigger_type;
	end

	// Pin synchroniser; idle level is high
	tfe_sync #(
		.RESET_VAL(tfe_pkg::PIN_IDLE)
	) u_pin_sync (
		.clk_i(sys_clk_i),
		.reset_i(reset_i),
		.d_i(ext_irq_one_pin_n_i),
		.q_o(pin_s)
	);

	// Previous sample taken from the synchronised level only
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			pin_prev_q <= tfe_pkg::PIN_IDLE;
		else
			pin_prev_q <= pin_s;
	end

	assign fall = pin_prev_q && !pin_s;

	// Detect flag; in level mode writes are overridden by the pin
	always_comb
	begin
		det_d = det_q;
		if (trig_type_q == tfe_pkg::TRIG_EDGE)
		begin
			if (ctrl_wr)
				det_d = wr_ctrl.ext_irq_one_detect_flag;
			else if (ext1_isr_enter_i)
				det_d = 1'b0;
			if (fall)
				det_d = 1'b1;
		end
		else
			det_d = !pin_s;
	end

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			det_q <= tfe_pkg::CTRL_RST[tfe_pkg::BIT_DET_FLAG];
		else
			det_q <= det_d;
	end

	// Sticky events on each flag rising, whatever raised it
	always_comb
	begin
		sts_set = '0;
		sts_set[tfe_pkg::IRQ_OVF] = ovf_flag_d && !ovf_flag_q;
		sts_set[tfe_pkg::IRQ_DET] = det_d && !det_q;
		sts_clr = '0;
		if (sts_wr)
			sts_clr = req.writedata[tfe_pkg::IRQ_W-1:0];
	end

	tfe_sticky #(
		.WIDTH(tfe_pkg::IRQ_W)
	) u_sts (
		.clk_i(sys_clk_i),
		.reset_i(reset_i),
		.set_i(sts_set),
		.clr_i(sts_clr),
		.q_o(sts)
	);

	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			msk_q <= tfe_pkg::IRQ_MSK_RST;
		else if (msk_wr)
			msk_q <= req.writedata[tfe_pkg::IRQ_W-1:0];
	end

	// Registered, so the line lags the status bit by one cycle
	always_ff @(posedge sys_clk_i or posedge reset_i)
	begin
		if (reset_i)
			irq_q <= 1'b0;
		else
			irq_q <= |(sts & msk_q);
	end

	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign timer_zero_run_o = run_q;
	assign timer_zero_overflow_flag_o = ovf_flag_q;
	assign ext_irq_one_detect_flag_o = det_q;
	assign ext_irq_one_trigger_type_o = trig_type_q;
	assign irq_o = irq_q;

	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (reset_i);

	chk_ovf_hw_set: assert property (
		timer_overflow_i |=> ovf_flag_q)
		else $error("overflow did not set the flag");

	chk_ovf_hold: assert property (
		(!timer_overflow_i && !t0_isr_enter_i && !ctrl_wr)
		|=> $stable(ovf_flag_q))
		else $error("overflow flag changed without a cause");

	chk_ovf_isr_clear: assert property (
		(t0_isr_enter_i && !timer_overflow_i && !ctrl_wr)
		|=> !ovf_flag_q)
		else $error("service entry did not clear overflow flag");

	chk_ovf_sw_write: assert property (
		(ctrl_wr && !timer_overflow_i)
		|=> ovf_flag_q == $past(req.writedata[tfe_pkg::BIT_OVF_FLAG]))
		else $error("software write to overflow flag lost");

	chk_run_bit_write: assert property (
		ctrl_wr |=> timer_zero_run_o ==
			$past(req.writedata[tfe_pkg::BIT_RUN]))
		else $error("run bit did not follow write");

	chk_run_hold: assert property (
		!ctrl_wr |=> $stable(timer_zero_run_o))
		else $error("run bit changed without a write");

	chk_det_edge_set: assert property (
		(trig_type_q && pin_s ##1 trig_type_q && !pin_s) |=> det_q)
		else $error("falling edge did not set detect flag");

	chk_det_edge_hold: assert property (
		(trig_type_q && !fall && !ext1_isr_enter_i && !ctrl_wr)
		|=> $stable(det_q))
		else $error("detect flag changed without an edge");

	chk_det_isr_clear: assert property (
		(trig_type_q && ext1_isr_enter_i && !fall && !ctrl_wr)
		|=> !det_q)
		else $error("edge flag not cleared at service entry");

	chk_det_level_track: assert property (
		!trig_type_q |=> det_q == !$past(pin_s))
		else $error("level flag does not follow pin");

	chk_type_write: assert property (
		ctrl_wr |=> ext_irq_one_trigger_type_o ==
			$past(req.writedata[tfe_pkg::BIT_TRIG_TYPE]))
		else $error("type bit did not follow write");

	chk_type_hold: assert property (
		!ctrl_wr |=> $stable(ext_irq_one_trigger_type_o))
		else $error("type bit changed without a write");

	// A low that was already low before gives no edge
	chk_edge_no_set: assert property (
		(trig_type_q && !pin_prev_q && !pin_s && !det_q && !ctrl_wr)
		|=> !det_q)
		else $error("steady low set detect flag in edge mode");

	chk_det_sw_write: assert property (
		(trig_type_q && ctrl_wr && !fall)
		|=> det_q == $past(req.writedata[tfe_pkg::BIT_DET_FLAG]))
		else $error("software write to detect flag lost");

	// Set beats a clear landing in the same cycle
	chk_sts_set_wins: assert property (
		(|sts_set) |=> (sts & $past(sts_set)) == $past(sts_set))
		else $error("status event lost");

	chk_sts_w1c: assert property (
		(sts_wr && !(|sts_set))
		|=> (sts & $past(req.writedata[tfe_pkg::IRQ_W-1:0])) == '0)
		else $error("status bit not cleared by writing one");

	chk_msk_write: assert property (
		msk_wr |=> msk_q == $past(req.writedata[tfe_pkg::IRQ_W-1:0]))
		else $error("mask did not follow write");

	chk_rdata_hold: assert property (
		!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
		else $error("read data changed without a read");

	chk_pin_readback: assert property (
		(avs_read_i && avs_waitrequest_o
		&& avs_address_i == tfe_pkg::OFS_PIN)
		|=> avs_readdata_o[tfe_pkg::BIT_PIN] == $past(pin_s))
		else $error("pin register read wrong level");

	chk_bus_one_wait: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("waitrequest handshake length wrong");

	chk_irq_follows: assert property (
		irq_o == $past(|(sts & msk_q)))
		else $error("interrupt line does not follow status");

	cov_ovf_isr: cover property (
		timer_overflow_i ##[1:20] t0_isr_enter_i);
	cov_edge_set: cover property (trig_type_q && fall);
	cov_level_low: cover property (!trig_type_q && !pin_s ##1 det_q);
	cov_lane_off: cover property (
		avs_write_i && !avs_waitrequest_o && !avs_byteenable_i[0]);
	cov_irq_raised: cover property (!irq_o ##1 irq_o);

endmodule

/* verification/tfe_core_model.sv */
// Behavioural core and pin source facing the flag block.
// Assumes the bench calls its tasks; every drive follows a rising edge.
`timescale 1ns/1ps
module tfe_core_model (
	// Clock
	input wire logic clk_i,
	// Strobes and pin
	output logic ovf_o,
	output logic t0_enter_o,
	output logic e1_enter_o,
	output logic pin_n_o
);
	logic [2:0] ev_q;
	assign ovf_o = ev_q[0];
	assign t0_enter_o = ev_q[1];
	assign e1_enter_o = ev_q[2];
	initial
	begin
		ev_q = 3'h0;
		pin_n_o = 1'b1;
	end
	// One-cycle strobe after dly idle cycles, as a slow core would
	task pulse(input int k, input int dly);
	begin
		repeat (dly + 1) @(posedge clk_i);
		ev_q[k] <= 1'b1;
		@(posedge clk_i);
		ev_q[k] <= 1'b0;
	end
	endtask
	// Pin has a pull-up, so idle is high
	task set_pin(input logic v);
	begin
		@(posedge clk_i);
		pin_n_o <= v;
	end
	endtask
endmodule

/* verification/test_timer0_flag_ext1_irq_detect.sv */
// Self-checking bench for the timer-0 flag and ext-irq-1 block.
// Assumes one design instance and the core model beside it.
`timescale 1ns/1ps
module test_timer0_flag_ext1_irq_detect;
	logic sys_clk = 1'b0;
	logic reset_i = 1'b1;
	logic [3:0] addr = 4'h0;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0] be = 4'hF;
	logic [3:0] wbe = 4'hF;
	logic [31:0] rdata;
	logic wreq, run, tf, det, typ, irq, ovf, t0e, e1e, pin;
	logic [3:0] ctl4;
	logic [31:0] q;
	int i;
	int fails = 0;
	int tests_run = 0;
	// Address, write data, expected readback
	logic [19:0] rows [9] = '{20'h01010, 20'h00000, 20'h02424,
		20'h00404, 20'h00C0C, 20'h00800, 20'h8FF03, 20'hC0001,
		20'h2FF00};
	assign ctl4 = {tf, run, det, typ};
	always #50 sys_clk = ~sys_clk;
	tfe_irq_ctrl dut (
		.sys_clk_i(sys_clk), .reset_i(reset_i),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_writedata_i(wdata), .avs_byteenable_i(be),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.timer_overflow_i(ovf), .t0_isr_enter_i(t0e),
		.ext1_isr_enter_i(e1e), .timer_zero_run_o(run),
		.timer_zero_overflow_flag_o(tf),
		.ext_irq_one_detect_flag_o(det),
		.ext_irq_one_trigger_type_o(typ),
		.ext_irq_one_pin_n_i(pin), .irq_o(irq)
	);
	tfe_core_model model (
		.clk_i(sys_clk), .ovf_o(ovf), .t0_enter_o(t0e),
		.e1_enter_o(e1e), .pin_n_o(pin)
	);
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
	begin
		tests_run++;
		if (g !== e)
		begin
			fails++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	end
	endtask
	task cyc(input int n);
	begin
		repeat (n) @(posedge sys_clk);
		#1;
	end
	endtask
	// Request held until the edge that sees waitrequest low
	task bus_wr(input logic [3:0] a, input logic [7:0] d);
	begin
		@(posedge sys_clk);
		addr <= a;
		wdata <= {24'h0, d};
		be <= wbe;
		wr <= 1'b1;
		@(posedge sys_clk iff wreq === 1'b0);
		wr <= 1'b0;
		#1;
	end
	endtask
	task bus_rd(input logic [3:0] a, output logic [31:0] d);
	begin
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk iff wreq === 1'b0);
		d = rdata;
		rd <= 1'b0;
		#1;
	end
	endtask
	// Far beyond the roughly 160 cycles the sequence needs
	initial
	begin
		#(100 * 20000);
		fails++;
		end_sim;
	end
	initial
	begin
		repeat (20) @(posedge sys_clk);
		chk("reset outputs", 32'h1, {26'h0, ctl4, irq, wreq});
		reset_i <= 1'b0;
		for (i = 0; i < 4; i++)
		begin
			bus_rd(4'(i * 4), q);
			chk("reset register", 32'(i == 3), q);
		end
		for (i = 0; i < 9; i++)
		begin
			bus_wr(rows[i][19:16], rows[i][15:8]);
			bus_rd(rows[i][19:16], q);
			chk("readback", {24'h0, rows[i][7:0]}, q);
			if (rows[i][19:16] == 4'h0)
				chk("ctrl pins", 32'(rows[i][5:2]), 32'(ctl4));
		end
		bus_wr(4'h4, 8'h03);
		bus_wr(4'h8, 8'h00);
		bus_rd(4'h4, q);
		chk("status cleared", 32'h0, q);
		model.pulse(0, 0);
		#1;
		chk("overflow flag", 32'h1, 32'(tf));
		cyc(2);
		chk("masked irq", 32'h0, 32'(irq));
		bus_rd(4'h4, q);
		chk("status set", 32'h1, q);
		bus_wr(4'h8, 8'h01);
		cyc(1);
		chk("irq raised", 32'h1, 32'(irq));
		model.pulse(1, 3);
		#1;
		chk("service clear", 32'h0, 32'(tf));
		bus_wr(4'h4, 8'h01);
		cyc(1);
		chk("irq cleared", 32'h0, 32'(irq));
		// Edge mode: one detect per falling edge
		bus_wr(4'h0, 8'h04);
		model.set_pin(1'b0);
		cyc(4);
		chk("edge detect", 32'h1, 32'(det));
		model.pulse(2, 1);
		#1;
		chk("edge service", 32'h0, 32'(det));
		cyc(4);
		chk("held low", 32'h0, 32'(det));
		model.set_pin(1'b1);
		// Level mode: flag follows the pin
		bus_wr(4'h0, 8'h00);
		model.set_pin(1'b0);
		cyc(4);
		chk("level detect", 32'h1, 32'(det));
		model.pulse(2, 0);
		cyc(1);
		chk("level service", 32'h1, 32'(det));
		model.set_pin(1'b1);
		cyc(4);
		chk("level release", 32'h0, 32'(det));
		// Write without low byte lane is dropped
		wbe = 4'h2;
		bus_wr(4'h0, 8'h10);
		wbe = 4'hF;
		cyc(1);
		chk("lane off", 32'h0, 32'(run));
		// Mid-run reset drops everything back to idle
		bus_wr(4'h0, 8'h30);
		chk("run before reset", 32'h1, 32'(run));
		@(posedge sys_clk);
		reset_i <= 1'b1;
		@(posedge sys_clk);
		reset_i <= 1'b0;
		#1;
		chk("mid reset outputs", 32'h1, {26'h0, ctl4, irq, wreq});
		bus_rd(4'h8, q);
		chk("mask after reset", 32'h0, q);
		bus_rd(4'h0, q);
		chk("ctrl after reset", 32'h0, q);
		end_sim;
	end
endmodule
